// ### logic/ocq_qualifier.sv
// Purpose: Qualify overcurrent windows and drive the open-drain alert
// Assumes: Comparator result and pins are asynchronous; 10 MHz mclk
// Notes: Pin sense and latch clear are plain inputs, each through a two-flop synchroniser
`timescale 1ns/100ps
`include "ocq_params.svh"
module ocq_qualifier (
    input wire logic mclk, // 10 MHz clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic over_in, // Comparator: averaged input above limit
    input wire ocq_pkg::ocq_pin_sense_t delay_pin, // Delay pin sense
    input wire logic latch_mode_in, // Output-mode pin
    input wire logic latch_clear, // Latch clear request
    output logic alert_n_o, // Alert pad output value, always low
    output logic alert_n_oe_n, // Alert pad enable, low while pulling
    output ocq_pkg::ocq_resp_t resp_o // Decoded response setting
);
    import ocq_pkg::*;
    // ==========================================
    // Two-flop synchronisers for all pins
    // Every pin is a slow level, so a pulse shorter than one clock may be missed
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {latch_clear, latch_mode_in, delay_pin, over_in};
            sync2_reg <= sync1_reg;
        end
    end
    wire over_s = sync2_reg[0];
    wire sense_high_s = sync2_reg[1];
    wire sense_low_s = sync2_reg[2];
    wire latch_mode_s = sync2_reg[3];
    wire clear_s = sync2_reg[4];
    // ==========================================
    // Window tick
    logic tick;
    ocq_window_timer u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .tick(tick)
    );
    // ==========================================
    // Delay pin decode; neither pull means floating
    // Supply wins if both sensed, a pin the other party must not create
    // Decoded continuously, so a strap change takes effect within three clocks
    wire ocq_resp_t resp_dec = sense_high_s ? OCQ_RESP_100 :
                               sense_low_s ? OCQ_RESP_50 : OCQ_RESP_10;
    ocq_resp_t resp_reg;
    logic [`OCQ_RUN_CNT_W-1:0] need;
    always_comb begin
        unique case (resp_reg)
            OCQ_RESP_10: need = `OCQ_RUN_SHORT;
            OCQ_RESP_50: need = `OCQ_RUN_MID;
            OCQ_RESP_100: need = `OCQ_RUN_LONG;
            default: need = `OCQ_RUN_SHORT;
        endcase
    end
    // ==========================================
    // Consecutive-window counter and alert state
    logic [`OCQ_RUN_CNT_W-1:0] run_reg;
    logic [`OCQ_RUN_CNT_W-1:0] run_next;
    logic alert_reg;
    logic alert_next;
    wire [`OCQ_RUN_CNT_W-1:0] run_inc = (run_reg >= need) ? need : run_reg + 1'b1;
    wire qualified = tick && over_s && (run_inc == need);
    // Counter saturates at the target so a long event keeps the alert held
    // Saturating at or above the target also copes with a shorter setting picked mid-run
    assign run_next = !tick ? run_reg : (over_s ? run_inc : '0);
    // Release only in transparent mode on a passing window; latch waits for clear
    // A qualifying window end beats a clear that arrives in the same cycle
    wire release_ok = latch_mode_s ? (clear_s && !qualified)
                                   : (tick && !over_s);
    assign alert_next = qualified ? 1'b1 : (release_ok ? 1'b0 : alert_reg);
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            run_reg <= '0;
            alert_reg <= 1'b0;
            resp_reg <= OCQ_RESP_10;
        end else begin
            run_reg <= run_next;
            alert_reg <= alert_next;
            resp_reg <= resp_dec;
        end
    end
    // ==========================================
    // Open-drain pad: value fixed low, enable low while pulling
    // Nothing ever drives the line high; the outside pull-up supplies the idle level
    logic oe_n_reg;
    logic val_reg;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            oe_n_reg <= 1'b1;
            val_reg <= 1'b0;
        end else begin
            oe_n_reg <= !alert_next;
            val_reg <= 1'b0;
        end
    end
    assign alert_n_oe_n = oe_n_reg;
    assign alert_n_o = val_reg;
    assign resp_o = resp_reg;
    // ==========================================
    // Window length watch for the checks below
    // A drifting window would stretch every delay setting by the same error
    localparam logic [`OCQ_WIN_CNT_W-1:0] GAP_LAST = `OCQ_WIN_CNT_W'(`OCQ_WINDOW_CYC - 1);
    logic [`OCQ_WIN_CNT_W-1:0] gap_reg;
    logic seen_tick_reg;
    // First window after reset is not measured, its start is not a tick
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            gap_reg <= '0;
            seen_tick_reg <= 1'b0;
        end else begin
            gap_reg <= tick ? '0 : gap_reg + 1'b1;
            seen_tick_reg <= seen_tick_reg | tick;
        end
    end
    // ==========================================
    // Checks
    // Window timing: one tick per window, and decisions only there
    AST_WINDOW_LEN: assert property (@(posedge mclk) disable iff (!nrst)
        (tick && seen_tick_reg) |-> gap_reg == GAP_LAST)
        else $error("Window tick came early or late");
    AST_WINDOW_DUE: assert property (@(posedge mclk) disable iff (!nrst)
        (seen_tick_reg && gap_reg == GAP_LAST) |-> tick)
        else $error("Window tick missing");
    AST_NO_TRIP_OFF_TICK: assert property (@(posedge mclk) disable iff (!nrst)
        (!alert_reg && !tick) |=> !alert_reg)
        else $error("Alert set away from window end");
    AST_RUN_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
        !tick |=> run_reg == $past(run_reg))
        else $error("Counter moved away from window end");
    AST_ALERT_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(alert_reg) |-> $past(tick) && $past(over_s))
        else $error("Alert rose without an over-threshold window end");
    // Short setting and the idle level
    AST_SHORT_TRIP: assert property (@(posedge mclk) disable iff (!nrst)
        (tick && over_s && resp_reg == OCQ_RESP_10) |=> alert_reg)
        else $error("Short setting did not trip");
    AST_IDLE_STAYS: assert property (@(posedge mclk) disable iff (!nrst)
        (!alert_reg && tick && !over_s) |=> !alert_reg)
        else $error("Alert set on passing window");
    // Middle and long settings count whole windows
    AST_MID_NOT_EARLY: assert property (@(posedge mclk) disable iff (!nrst)
        (!alert_reg && resp_reg == OCQ_RESP_50 && run_reg < (`OCQ_RUN_MID - 4'h1))
        |=> !alert_reg)
        else $error("Middle setting tripped early");
    AST_MID_TRIP: assert property (@(posedge mclk) disable iff (!nrst)
        (tick && over_s && resp_reg == OCQ_RESP_50 && run_reg == (`OCQ_RUN_MID - 4'h1))
        |=> alert_reg)
        else $error("Middle setting missed its last window");
    AST_RUN_STEP: assert property (@(posedge mclk) disable iff (!nrst)
        (tick && over_s && run_reg < need) |=> run_reg == $past(run_reg) + 4'h1)
        else $error("Counter did not step on an over-threshold window");
    AST_LONG_NOT_EARLY: assert property (@(posedge mclk) disable iff (!nrst)
        (!alert_reg && resp_reg == OCQ_RESP_100 && run_reg < (`OCQ_RUN_LONG - 4'h1))
        |=> !alert_reg)
        else $error("Long setting tripped early");
    AST_LONG_TRIP: assert property (@(posedge mclk) disable iff (!nrst)
        (tick && over_s && resp_reg == OCQ_RESP_100 && run_reg == (`OCQ_RUN_LONG - 4'h1))
        |=> alert_reg)
        else $error("Long setting missed its last window");
    AST_RUN_MAX: assert property (@(posedge mclk) disable iff (!nrst)
        run_reg <= `OCQ_RUN_LONG)
        else $error("Counter ran past the longest target");
    AST_RUN_RESET: assert property (@(posedge mclk) disable iff (!nrst)
        (tick && !over_s) |=> run_reg == 4'h0)
        else $error("Counter not cleared on passing window");
    // Delay pin decode, all three strap states
    AST_DECODE: assert property (@(posedge mclk) disable iff (!nrst)
        (sense_low_s && !sense_high_s) |=> resp_reg == OCQ_RESP_50)
        else $error("Ground pin not decoded as middle");
    AST_DECODE_SUPPLY: assert property (@(posedge mclk) disable iff (!nrst)
        sense_high_s |=> resp_reg == OCQ_RESP_100)
        else $error("Supply pin not decoded as long");
    AST_DECODE_FLOAT: assert property (@(posedge mclk) disable iff (!nrst)
        (!sense_high_s && !sense_low_s) |=> resp_reg == OCQ_RESP_10)
        else $error("Floating pin not decoded as short");
    // Transparent release and latched hold
    AST_TRANSPARENT_RELEASE: assert property (@(posedge mclk) disable iff (!nrst)
        (!latch_mode_s && tick && !over_s) |=> !alert_reg ##1 alert_n_oe_n)
        else $error("Transparent alert not released");
    AST_TRANSPARENT_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
        (alert_reg && !latch_mode_s && !tick) |=> alert_reg)
        else $error("Transparent alert dropped between window ends");
    AST_ALERT_FALL: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(alert_reg) |-> ($past(tick) && !$past(over_s)) ||
        ($past(latch_mode_s) && $past(clear_s)))
        else $error("Alert fell without a passing window or a clear");
    AST_LATCH_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
        (alert_reg && latch_mode_s && !clear_s) |=> alert_reg)
        else $error("Latched alert dropped without clear");
    AST_LATCH_PASS_WINDOW: assert property (@(posedge mclk) disable iff (!nrst)
        (alert_reg && latch_mode_s && !clear_s && tick && !over_s) |=> alert_reg)
        else $error("Latched alert followed a passing window");
    AST_LATCH_CLEAR: assert property (@(posedge mclk) disable iff (!nrst)
        (alert_reg && latch_mode_s && clear_s && !tick) |=> !alert_reg)
        else $error("Latched alert not cleared");
    // Pad mirrors the alert state
    AST_PAD_FOLLOWS: assert property (@(posedge mclk) disable iff (!nrst)
        alert_n_oe_n == !alert_reg)
        else $error("Pad enable does not follow alert");
    AST_PAD_VALUE_LOW: assert property (@(posedge mclk) disable iff (!nrst)
        !alert_n_o)
        else $error("Pad value not low");
endmodule

// ### logic/ocq_params.svh
// Purpose: Constants for the overcurrent delay qualifier
// Assumes: 10 MHz mclk
// Notes: Times in ns, counts derived from the clock period
`ifndef OCQ_PARAMS_SVH
`define OCQ_PARAMS_SVH
`define OCQ_CLK_PERIOD_NS 100
`define OCQ_WINDOW_NS 10000
`define OCQ_WINDOW_CYC (`OCQ_WINDOW_NS / `OCQ_CLK_PERIOD_NS)
`define OCQ_WIN_CNT_W 7
`define OCQ_RUN_CNT_W 4
`define OCQ_RUN_SHORT 4'h1
`define OCQ_RUN_MID 4'h5
`define OCQ_RUN_LONG 4'ha
`endif

// ### logic/ocq_pkg.sv
// Purpose: Types for the overcurrent delay qualifier
// Assumes: Nothing beyond the params header
// Notes: Pin decode encodings are one-hot
package ocq_pkg;
    // Response setting decoded from the three-state pin
    typedef enum logic [2:0] {
        OCQ_RESP_10 = 3'h1,
        OCQ_RESP_50 = 3'h2,
        OCQ_RESP_100 = 3'h4
    } ocq_resp_t;
    // Three-state pin as seen by the pad sense circuit
    typedef struct packed {
        logic pulled_low;
        logic pulled_high;
    } ocq_pin_sense_t;
endpackage

// ### logic/ocq_window_timer.sv
// Purpose: Free-running comparison window tick
// Assumes: Single clock, synchronous reset
// Notes: No external control of window boundaries
`timescale 1ns/100ps
`include "ocq_params.svh"
module ocq_window_timer (
    input wire logic mclk, // System clock
    input wire logic nrst, // Synchronous reset, active low
    output logic tick // One-cycle pulse at each window end
);
    import ocq_pkg::*;
    localparam logic [`OCQ_WIN_CNT_W-1:0] LAST = `OCQ_WIN_CNT_W'(`OCQ_WINDOW_CYC - 1);
    logic [`OCQ_WIN_CNT_W-1:0] cnt_reg;
    logic tick_reg;
    wire at_end = (cnt_reg == LAST);
    // ==========================================
    // Window counter, runs regardless of input
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= at_end ? '0 : cnt_reg + 1'b1;
            tick_reg <= at_end;
        end
    end
    assign tick = tick_reg;
    // Tick is never repeated within eight cycles of the last
    AST_TICK_SPACING: assert property (@(posedge mclk) disable iff (!nrst)
        tick |=> !tick [*8])
        else $error("Window tick repeated too soon");
endmodule

// ### tb/ocq_far_side.sv
// Purpose: Far side of the qualifier: delay pin strap and the pulled-up alert wire
// Assumes: One strap state at a time, a pull-up resistor on the alert line
// Notes: Behavioural only, no clock
`timescale 1ns/100ps
module ocq_far_side (
    input wire logic [1:0] sel, // Strap: 0 floating, 1 ground, 2 supply
    input wire logic alert_n_o, // Pad value from the block
    input wire logic alert_n_oe_n, // Pad enable, low while pulling
    output ocq_pkg::ocq_pin_sense_t delay_pin, // Pin sense seen by the block
    output logic alert_line // Resolved alert wire
);
    import ocq_pkg::*;
    // ==========================================
    // Strap and wire
    // Only one sense bit is ever set, so the pin is never half strapped
    assign delay_pin = ocq_pin_sense_t'({sel == 2'h1, sel == 2'h2});
    // Released pad floats up to the pull-up level, never the last value
    assign alert_line = alert_n_oe_n ? 1'b1 : alert_n_o;
endmodule

// ### tb/overcurrent_delay_qualifier_test.sv
// Purpose: Self-checking bench for the overcurrent delay qualifier
// Assumes: Window of 100 mclk cycles, first tick 100 cycles after reset release
// Notes: Inputs change mid-window so every window sees one clean level
`timescale 1ns/100ps
module overcurrent_delay_qualifier_test;
    import ocq_pkg::*;
    logic mclk = 1'b0, nrst = 1'b0, over_in = 1'b0, latch_mode_in = 1'b0, latch_clear = 1'b0;
    logic [1:0] sel = 2'h0;
    ocq_pin_sense_t delay_pin;
    logic alert_n_o, alert_n_oe_n, alert_line;
    ocq_resp_t resp_o;
    int n_mismatch = 0, checks = 0, seed = 19405, need, k;
    // ==========================================
    // Clock and instances
    always #50 mclk = ~mclk;
    ocq_qualifier u_ocq_qualifier (.mclk(mclk), .nrst(nrst), .over_in(over_in),
        .delay_pin(delay_pin), .latch_mode_in(latch_mode_in), .latch_clear(latch_clear),
        .alert_n_o(alert_n_o), .alert_n_oe_n(alert_n_oe_n), .resp_o(resp_o));
    ocq_far_side u_ocq_far_side (.sel(sel), .alert_n_o(alert_n_o),
        .alert_n_oe_n(alert_n_oe_n), .delay_pin(delay_pin), .alert_line(alert_line));
    // ==========================================
    // Helpers
    task check(input logic [2:0] seen, input logic [2:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Holds one comparator level for whole windows
    // Zero windows leaves the level alone, so one step never assigns it twice
    task wins(input logic lvl, input int n);
        if (n > 0) begin
            over_in <= lvl;
            repeat (n * 100) @(posedge mclk);
        end
    endtask
    function int need_of(input int s);
        return (s == 0) ? 1 : ((s == 1) ? 5 : 10);
    endfunction
    // Alert wire is low only once the run reaches the target
    function logic exp_line(input int runs, input int target);
        return (runs >= target) ? 1'b0 : 1'b1;
    endfunction
    task summarize;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        check({2'h0, alert_line}, 3'h1);
        check(resp_o, OCQ_RESP_10);
        nrst <= 1'b1;
        repeat (50) @(posedge mclk);
        for (int s = 0; s < 3; s++) begin
            sel <= 2'(s);
            wins(1'b0, 2);
            check(resp_o, 3'(1 << s));
            need = need_of(s);
            // Random short run, then one passing window must wipe it
            k = (need > 1) ? 1 + ($unsigned($random(seed)) % (need - 1)) : 0;
            if (k > 0) wins(1'b1, k);
            check({2'h0, alert_line}, {2'h0, exp_line(k, need)});
            wins(1'b0, 1);
            check({2'h0, alert_line}, 3'h1);
            wins(1'b1, need - 1);
            check({2'h0, alert_line}, {2'h0, exp_line(need - 1, need)});
            wins(1'b1, 1);
            check({2'h0, alert_line}, 3'h0);
            wins(1'b0, 1);
            check({2'h0, alert_line}, 3'h1);
        end
        // Latched mode keeps the alert past the event until cleared
        sel <= 2'h0;
        latch_mode_in <= 1'b1;
        wins(1'b0, 2);
        wins(1'b1, 1);
        check({2'h0, alert_line}, 3'h0);
        wins(1'b0, 2);
        check({2'h0, alert_line}, 3'h0);
        latch_clear <= 1'b1;
        wins(1'b0, 1);
        latch_clear <= 1'b0;
        wins(1'b0, 1);
        check({2'h0, alert_line}, 3'h1);
        // Reset in mid-event drops a latched alert and restarts the window
        wins(1'b1, 1);
        check({2'h0, alert_line}, 3'h0);
        over_in <= 1'b0;
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        check({2'h0, alert_line}, 3'h1);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        check({2'h0, alert_line}, 3'h1);
        check(resp_o, OCQ_RESP_10);
        repeat (48) @(posedge mclk);
        wins(1'b1, 1);
        check({2'h0, alert_line}, 3'h0);
        summarize;
    end
endmodule
